// [rtl/bhc_pkg.sv]
package bhc_pkg;

  // setup byte addresses on the host serial link
  localparam logic [7:0] ADDR_CTRL  = 8'hf4;
  localparam logic [7:0] ADDR_IDLE0 = 8'hf5;
  localparam logic [7:0] ADDR_IDLE1 = 8'hf6;
  localparam logic [7:0] ADDR_IDLE2 = 8'hf7;

  // values after reset: hop mode 3, all other control fields 0
  localparam logic [7:0] RST_CTRL  = 8'hc0;
  localparam logic [7:0] RST_IDLE0 = 8'h01;
  localparam logic [7:0] RST_IDLE1 = 8'h06;
  localparam logic [7:0] RST_IDLE2 = 8'h3f;
  localparam logic [8:0] RST_SWEEP = 9'h001;

  // field positions in the control byte
  localparam int DWELL_LSB   = 0;
  localparam int RESTART_BIT = 3;
  localparam int MULT_LSB    = 4;
  localparam int HOP_LSB     = 6;

  // charge-capture duration, least times rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 40;
  localparam int DWELL_MIN_NS  = 125;
  localparam int DWELL_MAX_NS  = 4500;
  localparam int DWELL_MIN_CYC =
    (DWELL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL_MAX_CYC =
    (DWELL_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL_STEPS   = 7;

  // burst and scan shape
  localparam logic [3:0] LAST_PULSE = 4'hf;    // 16 pulses per burst
  localparam logic [4:0] LAST_KEY   = 5'h17;   // 24 keys per scan
  localparam logic [8:0] IDLE_ZERO  = 9'h100;  // stored 0 means 256

  typedef enum logic [1:0] {
    HOP_FIXED, HOP_RECAL, HOP_ADJUST, HOP_SWEEP
  } bhc_hop_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_CHARGE, ST_GAP, ST_HOLD
  } bhc_state_t;

  // linear spread between the shortest and longest dwell
  function automatic logic [6:0] dwell_cycles(input logic [2:0] code);
    int c;
    c = DWELL_MIN_CYC
      + ((DWELL_MAX_CYC - DWELL_MIN_CYC) * int'(code)) / DWELL_STEPS;
    return c[6:0];
  endfunction

  function automatic logic [8:0] idle_cycles(input logic [7:0] v);
    return (v == 8'h00) ? IDLE_ZERO : {1'b0, v};
  endfunction

endpackage

// [rtl/bhc_nint_if.sv]
`timescale 1ns/100ps
interface bhc_nint_if;
  logic       inc;
  logic       clr;
  logic [3:0] limit;
  logic       reached;

  modport ctl (output inc, output clr, output limit, input reached);
  modport cnt (input inc, input clr, input limit, output reached);
endinterface

// [rtl/bhc_nint.sv]
`timescale 1ns/100ps
module bhc_nint (
  input wire logic clk,
  input wire logic rst_n,
  bhc_nint_if.cnt  port
);

  typedef struct packed {
    logic [3:0] count;
  } bhc_nint_t;

  bhc_nint_t cur_ff;
  bhc_nint_t nxt_cur;

  // an increment in the clearing cycle is kept, not lost
  always_comb begin
    nxt_cur = cur_ff;
    if (port.clr) begin
      nxt_cur.count = port.inc ? 4'h1 : 4'h0;
    end else if (port.inc && cur_ff.count != 4'hf) begin
      nxt_cur.count = cur_ff.count + 4'h1;  // saturates, never wraps
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign port.reached = (cur_ff.count >= port.limit);

endmodule

// [rtl/bhc_top.sv]
`timescale 1ns/100ps
module bhc_top (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        SETUP_WR,
  input  wire logic        SETUP_RD,
  input  wire logic [7:0]  SETUP_ADDR,
  input  wire logic [7:0]  SETUP_WDATA,
  output logic      [7:0]  SETUP_RDATA,
  input  wire logic        HOST_BUSY,
  input  wire logic        CAL_BUSY,
  input  wire logic        DELTA_VALID,
  input  wire logic [11:0] DELTA,
  input  wire logic [7:0]  NOISE_THRESHOLD,
  input  wire logic [3:0]  NOISE_LIMIT,
  input  wire logic [7:0]  KEY_THRESHOLD,
  output logic      [10:0] OP_THRESHOLD,
  output logic             ACQ_DRIVE,
  output logic             BURST_ACTIVE,
  output logic             BURST_DONE,
  output logic             BURST_NOISY,
  output logic             BURST_RESTART,
  output logic      [4:0]  KEY_INDEX,
  output logic             SCAN_DONE,
  output logic      [1:0]  FREQ_SELECT,
  output logic      [8:0]  IDLE_CYCLES,
  output logic             RECAL_ALL,
  output logic             REF_ADJUST
);

  typedef struct packed {
    bhc_pkg::bhc_state_t st;
    logic [7:0]          ctrl;
    logic [7:0]          idle0;
    logic [7:0]          idle1;
    logic [7:0]          idle2;
    logic [7:0]          rdata;
    bhc_pkg::bhc_hop_t   act_hop;
    logic                act_restart;
    logic [1:0]          act_mult;
    logic [6:0]          act_dwell;
    logic [8:0]          act_idle;
    logic [8:0]          cnt;
    logic [3:0]          pulse;
    logic [4:0]          key;
    logic [1:0]          fsel;
    logic [8:0]          sweep;
    logic                drive;
    logic                active;
    logic                done;
    logic                noisy;
    logic                restart;
    logic                scan_done;
    logic                recal;
    logic                adjust;
    logic                pos_inc;
    logic                neg_inc;
    logic                nclr;
    logic [10:0]         opthr;
  } bhc_top_t;

  bhc_top_t cur_ff;
  bhc_top_t nxt_cur;

  bhc_nint_if pos_if ();
  bhc_nint_if neg_if ();

  // one saturating integrator per delta polarity
  bhc_nint u_pos (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .port  (pos_if)
  );

  bhc_nint u_neg (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .port  (neg_if)
  );

  // both integrators share the scan-end clear and the limit
  assign pos_if.inc   = cur_ff.pos_inc;
  assign neg_if.inc   = cur_ff.neg_inc;
  assign pos_if.clr   = cur_ff.nclr;
  assign neg_if.clr   = cur_ff.nclr;
  assign pos_if.limit = NOISE_LIMIT;
  assign neg_if.limit = NOISE_LIMIT;

  // control fields as software last wrote them
  logic [1:0]  set_hop;
  logic        set_restart;
  logic [1:0]  set_mult;
  logic [2:0]  set_dwell;
  logic [11:0] delta_mag;
  logic        delta_neg;
  logic        noisy_delta;
  logic        hop_ok;
  logic        last_pulse;
  logic        last_key;
  logic [8:0]  idle1_cyc;
  logic [8:0]  idle0_cyc;

  assign set_hop     = cur_ff.ctrl[bhc_pkg::HOP_LSB +: 2];
  assign set_restart = cur_ff.ctrl[bhc_pkg::RESTART_BIT];
  assign set_mult    = cur_ff.ctrl[bhc_pkg::MULT_LSB +: 2];
  assign set_dwell   = cur_ff.ctrl[bhc_pkg::DWELL_LSB +: 3];
  // a stored 0 stands for the longest gap, 256 cycles
  assign idle0_cyc   = bhc_pkg::idle_cycles(cur_ff.idle0);
  assign idle1_cyc   = bhc_pkg::idle_cycles(cur_ff.idle1);

  // delta magnitude against the noise threshold, either polarity
  assign delta_neg   = DELTA[11];
  assign delta_mag   = delta_neg ? (12'h000 - DELTA) : DELTA;
  assign noisy_delta = DELTA_VALID
                     && (delta_mag >= {4'h0, NOISE_THRESHOLD});

  // a hop needs both integrators at the limit and no calibration;
  // a blocked hop still clears the counters, so noise must persist
  assign hop_ok = pos_if.reached && neg_if.reached && !CAL_BUSY;

  // burst and scan end markers
  assign last_pulse = (cur_ff.pulse == bhc_pkg::LAST_PULSE);
  assign last_key   = (cur_ff.key == bhc_pkg::LAST_KEY);

  // idle count for the burst about to start;
  // mode 3 ignores the index and the tertiary setting
  function automatic logic [8:0] pick_idle(
    input bhc_pkg::bhc_hop_t hop,
    input logic [1:0]        fsel,
    input logic [8:0]        sweep,
    input logic [7:0]        i0,
    input logic [7:0]        i1,
    input logic [7:0]        i2
  );
    logic [8:0] r;
    r = bhc_pkg::idle_cycles(i0);
    case (hop)
      bhc_pkg::HOP_RECAL,
      bhc_pkg::HOP_ADJUST: begin
        case (fsel)
          2'h1:    r = bhc_pkg::idle_cycles(i1);
          2'h2:    r = bhc_pkg::idle_cycles(i2);
          default: r = bhc_pkg::idle_cycles(i0);
        endcase
      end
      bhc_pkg::HOP_SWEEP: r = sweep;
      default:            r = bhc_pkg::idle_cycles(i0);
    endcase
    return r;
  endfunction

  // next state: setup access, noise counting, burst sequencing
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done      = 1'b0;
    nxt_cur.restart   = 1'b0;
    nxt_cur.scan_done = 1'b0;
    nxt_cur.recal     = 1'b0;
    nxt_cur.adjust    = 1'b0;
    nxt_cur.nclr      = 1'b0;

    // setup writes; unmapped addresses are ignored
    if (SETUP_WR) begin
      case (SETUP_ADDR)
        bhc_pkg::ADDR_CTRL:  nxt_cur.ctrl  = SETUP_WDATA;
        bhc_pkg::ADDR_IDLE0: nxt_cur.idle0 = SETUP_WDATA;
        bhc_pkg::ADDR_IDLE1: nxt_cur.idle1 = SETUP_WDATA;
        bhc_pkg::ADDR_IDLE2: nxt_cur.idle2 = SETUP_WDATA;
        default: ;
      endcase
    end

    // read data, registered; unmapped addresses read zero
    if (SETUP_RD) begin
      case (SETUP_ADDR)
        bhc_pkg::ADDR_CTRL:  nxt_cur.rdata = cur_ff.ctrl;
        bhc_pkg::ADDR_IDLE0: nxt_cur.rdata = cur_ff.idle0;
        bhc_pkg::ADDR_IDLE1: nxt_cur.rdata = cur_ff.idle1;
        bhc_pkg::ADDR_IDLE2: nxt_cur.rdata = cur_ff.idle2;
        default:             nxt_cur.rdata = 8'h00;
      endcase
    end

    // noise counting only in hop modes 1 and 2, in every state, burst or not
    nxt_cur.pos_inc = 1'b0;
    nxt_cur.neg_inc = 1'b0;
    if ((cur_ff.act_hop == bhc_pkg::HOP_RECAL
         || cur_ff.act_hop == bhc_pkg::HOP_ADJUST) && noisy_delta) begin
      nxt_cur.pos_inc = !delta_neg;
      nxt_cur.neg_inc = delta_neg;
    end

    // operating threshold follows the multiplier of the running burst
    nxt_cur.opthr = 11'({3'h0, KEY_THRESHOLD} << cur_ff.act_mult);

    case (cur_ff.st)
      bhc_pkg::ST_IDLE: begin
        // host traffic has priority, so a burst never starts under it
        if (!HOST_BUSY) begin
          nxt_cur.act_hop   = bhc_pkg::bhc_hop_t'(set_hop);
          // latched here so a write never bends a running burst
          nxt_cur.act_restart = set_restart;
          nxt_cur.act_mult  = set_mult;
          nxt_cur.act_dwell = bhc_pkg::dwell_cycles(set_dwell);
          nxt_cur.act_idle  = pick_idle(
            bhc_pkg::bhc_hop_t'(set_hop), cur_ff.fsel, cur_ff.sweep,
            cur_ff.idle0, cur_ff.idle1, cur_ff.idle2);
          nxt_cur.pulse  = 4'h0;
          nxt_cur.noisy  = 1'b0;
          nxt_cur.cnt    = {2'b00, nxt_cur.act_dwell} - 9'h001;
          nxt_cur.active = 1'b1;
          nxt_cur.st     = bhc_pkg::ST_CHARGE;
        end
      end

      bhc_pkg::ST_CHARGE,
      bhc_pkg::ST_GAP: begin
        // host traffic either aborts the burst or freezes its timing
        if (HOST_BUSY && cur_ff.act_restart) begin
          nxt_cur.st = bhc_pkg::ST_HOLD;
        end else if (HOST_BUSY) begin
          nxt_cur.noisy = 1'b1;
        end else if (cur_ff.cnt != 9'h000) begin
          nxt_cur.cnt = cur_ff.cnt - 9'h001;
        end else if (cur_ff.st == bhc_pkg::ST_CHARGE) begin
          nxt_cur.cnt = cur_ff.act_idle - 9'h001;
          nxt_cur.st  = bhc_pkg::ST_GAP;
        end else if (!last_pulse) begin
          nxt_cur.pulse = cur_ff.pulse + 4'h1;
          nxt_cur.cnt   = {2'b00, cur_ff.act_dwell} - 9'h001;
          nxt_cur.st    = bhc_pkg::ST_CHARGE;
        end else begin
          // burst complete; key result goes out with its noise flag
          nxt_cur.done   = 1'b1;
          nxt_cur.active = 1'b0;
          nxt_cur.st     = bhc_pkg::ST_IDLE;
          nxt_cur.key    = last_key ? 5'h00 : cur_ff.key + 5'h01;
          if (last_key) begin
            nxt_cur.scan_done = 1'b1;
            nxt_cur.nclr      = 1'b1;
            case (cur_ff.act_hop)
              bhc_pkg::HOP_RECAL,
              bhc_pkg::HOP_ADJUST: begin
                if (hop_ok) begin
                  nxt_cur.fsel = (cur_ff.fsel == 2'h2) ? 2'h0
                               : cur_ff.fsel + 2'h1;
                  nxt_cur.recal  =
                    (cur_ff.act_hop == bhc_pkg::HOP_RECAL);
                  nxt_cur.adjust =
                    (cur_ff.act_hop == bhc_pkg::HOP_ADJUST);
                end
              end
              bhc_pkg::HOP_SWEEP: begin
                // step one cycle per scan, wrap back to the primary;
                // no reference action at all in this mode
                if (cur_ff.sweep >= idle1_cyc
                    || cur_ff.sweep < idle0_cyc) begin
                  nxt_cur.sweep = idle0_cyc;
                end else begin
                  nxt_cur.sweep = cur_ff.sweep + 9'h001;
                end
              end
              // index left alone, mode 0 reads only the primary
              default: nxt_cur.fsel = cur_ff.fsel;
            endcase
          end
        end
      end

      bhc_pkg::ST_HOLD: begin
        // aborted burst reruns from its first pulse, same settings;
        // the restart pulse tells the consumer to drop partial data
        if (!HOST_BUSY) begin
          nxt_cur.restart = 1'b1;
          nxt_cur.pulse   = 4'h0;
          nxt_cur.cnt     = {2'b00, cur_ff.act_dwell} - 9'h001;
          nxt_cur.st      = bhc_pkg::ST_CHARGE;
        end
      end

      default: nxt_cur.st = bhc_pkg::ST_IDLE;
    endcase

    // drive is off while the host holds the device
    nxt_cur.drive = (nxt_cur.st == bhc_pkg::ST_CHARGE) && !HOST_BUSY;
  end

  // one register for the whole state
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // sweep starts at the primary reset value, index at 0
      cur_ff           <= '0;
      cur_ff.st        <= bhc_pkg::ST_IDLE;
      cur_ff.ctrl      <= bhc_pkg::RST_CTRL;
      cur_ff.idle0     <= bhc_pkg::RST_IDLE0;
      cur_ff.idle1     <= bhc_pkg::RST_IDLE1;
      cur_ff.idle2     <= bhc_pkg::RST_IDLE2;
      cur_ff.act_hop   <= bhc_pkg::HOP_SWEEP;
      cur_ff.sweep     <= bhc_pkg::RST_SWEEP;
      cur_ff.act_idle  <= bhc_pkg::RST_SWEEP;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // every output straight from the state register
  assign SETUP_RDATA   = cur_ff.rdata;
  assign OP_THRESHOLD  = cur_ff.opthr;
  assign ACQ_DRIVE     = cur_ff.drive;
  assign BURST_ACTIVE  = cur_ff.active;
  assign BURST_DONE    = cur_ff.done;
  assign BURST_NOISY   = cur_ff.noisy;
  assign BURST_RESTART = cur_ff.restart;
  assign KEY_INDEX     = cur_ff.key;
  assign SCAN_DONE     = cur_ff.scan_done;
  assign FREQ_SELECT   = cur_ff.fsel;
  assign IDLE_CYCLES   = cur_ff.act_idle;
  assign RECAL_ALL     = cur_ff.recal;
  assign REF_ADJUST    = cur_ff.adjust;

endmodule

// [test/bhc_assertions.sv]
`timescale 1ns/100ps
module bhc_assertions (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        SETUP_WR,
  input wire logic [7:0]  SETUP_ADDR,
  input wire logic [7:0]  SETUP_WDATA,
  input wire logic        HOST_BUSY,
  input wire logic [7:0]  KEY_THRESHOLD,
  input wire logic [10:0] OP_THRESHOLD,
  input wire logic        ACQ_DRIVE,
  input wire logic        BURST_ACTIVE,
  input wire logic        BURST_DONE,
  input wire logic        SCAN_DONE,
  input wire logic [4:0]  KEY_INDEX,
  input wire logic [1:0]  FREQ_SELECT,
  input wire logic        RECAL_ALL,
  input wire logic        REF_ADJUST
);
  logic [1:0] mul_ff;
  logic       run_ff;
  logic [7:0] pend_ff;
  logic [7:0] prev_ff;
  logic       act_ff;

  // shadow multiplier taken at burst start from the control byte
  // that stood before that edge; run_ff masks the first edge
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mul_ff  <= 2'h0;
      run_ff  <= 1'b0;
      pend_ff <= bhc_pkg::RST_CTRL;
      prev_ff <= bhc_pkg::RST_CTRL;
      act_ff  <= 1'b0;
    end else begin
      run_ff  <= 1'b1;
      act_ff  <= BURST_ACTIVE;
      prev_ff <= pend_ff;
      if (SETUP_WR && SETUP_ADDR == bhc_pkg::ADDR_CTRL) begin
        pend_ff <= SETUP_WDATA;
      end
      if (BURST_ACTIVE && !act_ff) begin
        mul_ff <= prev_ff[5:4];
      end
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_busy2;
    HOST_BUSY ##1 HOST_BUSY;
  endsequence
  sequence s_hop;
    RECAL_ALL || REF_ADJUST;
  endsequence

  a_thr_scaled: assert property (run_ff |-> OP_THRESHOLD ==
    ({3'h0, $past(KEY_THRESHOLD)} << mul_ff))
    else $error("scaled threshold wrong");
  a_acq_in_burst: assert property (ACQ_DRIVE |-> BURST_ACTIVE)
    else $error("charge phase outside burst");
  a_done_closes: assert property (
    BURST_DONE |-> !BURST_ACTIVE && !ACQ_DRIVE)
    else $error("burst still running at done");
  a_scan_on_done: assert property (SCAN_DONE |-> BURST_DONE)
    else $error("scan end without burst end");
  a_scan_wraps: assert property (
    SCAN_DONE |-> ##[0:1] KEY_INDEX == 5'h00)
    else $error("key index not back to 0");
  a_key_range: assert property (KEY_INDEX <= 5'h17)
    else $error("key index beyond 23");
  a_hop_at_scan: assert property (
    s_hop |-> SCAN_DONE && !(RECAL_ALL && REF_ADJUST))
    else $error("hop pulse off scan end");
  a_freq_moves: assert property (
    $changed(FREQ_SELECT) |-> RECAL_ALL || REF_ADJUST)
    else $error("frequency index moved without hop");
  a_busy_pause: assert property (s_busy2 |-> !ACQ_DRIVE)
    else $error("charge phase under host traffic");
endmodule

// [test/bhc_host.sv]
`timescale 1ns/100ps
module bhc_host (
  input  wire logic       clk,
  output logic            wr,
  output logic            rd,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            busy,
  input  wire logic [7:0] rdata
);
  // idle bus shows inverted values so stale data cannot pass
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    busy = 1'b0;
  end

  // one-cycle write strobe, taken at the rising edge between
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask

  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    @(negedge clk);
    d = rdata;
  endtask

  // serial traffic holding the device for n cycles
  task automatic talk(input int n);
    @(negedge clk);
    busy = 1'b1;
    repeat (n) @(negedge clk);
    busy = 1'b0;
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst_n, cal, dv, noisy, wr, rd, busy, acq, act;
  logic        done, nsy, rst, scan, recal, adj;
  logic [11:0] delta;
  logic [7:0]  kthr, rdata, addr, wdata, v;
  logic [10:0] op;
  logic [4:0]  key;
  logic [1:0]  fsel;
  logic [8:0]  idle;
  int          n_errors, tests_run, n_recal, n_adj, n_rst;

  bhc_host i_host (.clk(clk), .wr(wr), .rd(rd), .addr(addr),
    .wdata(wdata), .busy(busy), .rdata(rdata));

  bhc_top i_dut (.REF_CLK(clk), .RST_N(rst_n), .SETUP_WR(wr),
    .SETUP_RD(rd), .SETUP_ADDR(addr), .SETUP_WDATA(wdata),
    .SETUP_RDATA(rdata), .HOST_BUSY(busy), .CAL_BUSY(cal),
    .DELTA_VALID(dv), .DELTA(delta), .NOISE_THRESHOLD(8'h0a),
    .NOISE_LIMIT(4'h2), .KEY_THRESHOLD(kthr), .OP_THRESHOLD(op),
    .ACQ_DRIVE(acq), .BURST_ACTIVE(act), .BURST_DONE(done),
    .BURST_NOISY(nsy), .BURST_RESTART(rst), .KEY_INDEX(key),
    .SCAN_DONE(scan), .FREQ_SELECT(fsel), .IDLE_CYCLES(idle),
    .RECAL_ALL(recal), .REF_ADJUST(adj));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // alternating-polarity deltas feed both noise counters
  always @(negedge clk) begin
    dv <= noisy & ~dv;
    if (dv) delta <= 12'h000 - delta;
  end

  // pulse counters, so no one-cycle pulse is missed
  always @(posedge clk) begin
    n_recal <= n_recal + int'(recal);
    n_adj <= n_adj + int'(adj);
    n_rst <= n_rst + int'(rst);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // wait for n burst or scan ends, bounded
  task automatic await(input bit s, input int n);
    int k;
    k = 0;
    while (n > 0 && k < 30000) begin
      @(posedge clk);
      #1;
      if (s ? scan : done) n--;
      k++;
    end
    @(posedge clk);
    #1;
    check({15'h0, n > 0}, 16'h0000);
  endtask

  task automatic t_sweep;
    i_host.get(8'hf4, v);
    check(v, 8'hc0);
    await(1, 1); // reset idle bytes 1 and 6 are a legal sweep
    repeat (3) @(negedge clk);
    check(idle, 9'h002);
    await(1, 1);
    repeat (3) @(negedge clk);
    check(idle, 9'h003);
    check(16'(n_recal + n_adj), 16'h0000);
    $display("sweep test done");
  endtask

  task automatic t_regs;
    i_host.put(8'hf6, 8'h10);
    i_host.put(8'hf8, 8'h55);
    i_host.get(8'hf6, v);
    check(v, 8'h10);
    i_host.get(8'hf8, v);
    check(v, 8'h00);
    for (int m = 0; m < 4; m++) begin
      i_host.put(8'hf4, {2'h0, 2'(m), 4'h0});
      await(0, 1);
      repeat (2) @(negedge clk);
      check(op, 11'h0ff << m);
    end
    $display("register test done");
  endtask

  // measures one inner gap and the following charge phase
  task automatic t_timing(input logic [2:0] c, input logic [7:0] f);
    int h, l;
    i_host.put(8'hf5, f);
    i_host.put(8'hf4, {5'h00, c});
    await(0, 2);
    h = 0;
    l = 0;
    while (!acq && h < 600) begin @(posedge clk); #1; h++; end
    while (acq && h < 900) begin @(posedge clk); #1; h++; end
    h = 0;
    while (!acq && l < 600) begin @(posedge clk); #1; l++; end
    while (acq && h < 600) begin @(posedge clk); #1; h++; end
    check(16'(h), 16'(4 + 109 * c / 7));
    check(16'(l), f == 8'h00 ? 16'h0100 : {8'h00, f});
    check(idle, f == 8'h00 ? 9'h100 : {1'b0, f});
    $display("timing test done");
  endtask

  task automatic t_hop;
    int r;
    i_host.put(8'hf5, 8'h01);
    i_host.put(8'hf6, 8'h02);
    i_host.put(8'hf7, 8'h03);
    i_host.put(8'hf4, 8'h40);
    await(1, 1);
    r = n_recal;
    @(negedge clk);
    noisy = 1'b1;
    await(1, 1);
    check(fsel, 2'h1);
    check(16'(n_recal - r), 16'h0001);
    @(negedge clk);
    cal = 1'b1;
    await(1, 1);
    check(fsel, 2'h1);
    @(negedge clk);
    cal = 1'b0;
    r = n_adj;
    i_host.put(8'hf4, 8'h80);
    await(1, 1);
    check(fsel, 2'h2);
    check(16'(n_adj - r), 16'h0001);
    @(negedge clk);
    noisy = 1'b0;
    await(1, 2);
    check(fsel, 2'h2);
    check(idle, 9'h003);
    $display("hop test done");
  endtask

  task automatic t_restart(input logic on);
    int r;
    int k;
    i_host.put(8'hf4, {4'h0, on, 3'h0});
    await(0, 2);
    r = n_rst;
    repeat (10) @(negedge clk);
    i_host.talk(4);
    k = 0;
    while (!done && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    check({14'h0, k >= 2000, nsy}, {15'h0, ~on});
    @(posedge clk);
    #1;
    check(16'(n_rst - r), {15'h0, on});
    $display("restart test done");
  endtask

  initial begin
    rst_n = 1'b0;
    cal = 1'b0;
    dv = 1'b0;
    noisy = 1'b0;
    delta = 12'h064;
    kthr = 8'hff;
    n_errors = 0;
    tests_run = 0;
    n_recal = 0;
    n_adj = 0;
    n_rst = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_sweep();
    t_regs();
    t_timing(3'h0, 8'h03);
    t_timing(3'h7, 8'h00);
    t_timing(3'h3, 8'hff);
    t_hop();
    t_restart(1'b1);
    t_restart(1'b0);
    print_verdict();
  end

  // whole run needs well under 90000 cycles
  initial begin
    #3600000;
    n_errors++;
    print_verdict();
  end
endmodule

bind bhc_top bhc_assertions i_chk (.REF_CLK, .RST_N, .SETUP_WR,
  .SETUP_ADDR, .SETUP_WDATA, .HOST_BUSY, .KEY_THRESHOLD,
  .OP_THRESHOLD, .ACQ_DRIVE, .BURST_ACTIVE, .BURST_DONE, .SCAN_DONE,
  .KEY_INDEX, .FREQ_SELECT, .RECAL_ALL, .REF_ADJUST);
